// [core/drc_pkg.sv]
/*
  Constants for the DRAM refresh and configuration block.
  Assumes a 40 MHz system clock and the indexed port access used by the
  core (index write, then data read or write).
*/
package drc_pkg;

  // ----------------------------------------------------------------
  // Clock and refresh timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int STD_PERIOD_NS = 15625;
  localparam int SLOW_PERIOD_NS = 125000;
  localparam int STD_PERIOD_CYC = (STD_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int SLOW_PERIOD_CYC = (SLOW_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int MEMR_DELAY_SLOTCLK = 1;
  localparam int MEMR_LOW_SLOTCLK = 2;
  localparam int REF_ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MAP = 8'h03;
  localparam logic [7:0] IDX_CTL = 8'h05;
  localparam logic [7:0] IDX_REF = 8'h06;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MAP_RSVD_BIT = 7;
  localparam int CTL_WS_BIT = 4;
  localparam int CTL_FAST_BIT = 3;
  localparam int CTL_PAGE_MODE_DISABLE_BIT = 2;
  localparam int CTL_PAR_BIT = 1;
  localparam int CTL_RAS_BIT = 0;
  localparam int REF_CBR_BIT = 1;
  localparam int REF_SLOW_BIT = 0;
  localparam logic RST_FAST = 1'b0;
  localparam logic RST_PAR_N = 1'b0;
  localparam logic RST_RAS_SHUTOFF = 1'b0;
  localparam logic [1:0] RST_REFRESH_CONTROL_REGISTER = 2'h0;

  // Refresh sequencer states, Gray from DRC_IDLE through DRC_DONE
  typedef enum logic [2:0] {
    DRC_IDLE = 3'b000,
    DRC_WAIT = 3'b001,
    DRC_LEAD = 3'b011,
    DRC_MEMR = 3'b010,
    DRC_DONE = 3'b110
  } drc_state_t;

endpackage

// [core/drc_refresh.sv]
/*
  DRAM refresh generator and the map, control and refresh registers.
  Assumes synchronous inputs, a slot clock edge pulse on i_slot_clk_edge,
  and a memory controller that reports its busy state and wait-state needs.
*/
// What this block does
// - Full array refreshed within 64 ms or 512 ms by period select bit
// - Refresh is RAS-only or CAS-before-RAS by the CBR enable bit
// - Memory read strobe falls at least one slot clock after refresh
// - Memory read strobe held low two slot clocks unless stretched
// - Slot ready low keeps both strobes asserted until it returns high
// - Twelve-bit refresh counter driven onto address lines 11 to 0
// - Address 16-12 driven high, page register on address 23-17
// - Refresh counter increments when refresh strobe deasserts
// - Map register bit 7 reads as one always
// - ROM move bits redirect C segment on board, E segment to slot
// - ROM move bits load from strap pins 8 and 7 at reset end
// - Remap bit moves 384K to top only for 1M to 4M memory
// - Remap bit loads from strap pin 4 at reset end
// - Memory map bits select map, load from strap pins 3 to 0
// - Wait-state bit one adds one wait state, zero adds none except on page-miss bank-hit
// - Page-miss bank-hit with wait-state bit zero: 2 waits if fast-miss 0, else 3
// - Wait-state bit loads from strap pin 5 at reset end
// - Page mode disable bit, one disables, loads from strap pin 6
// - Parity enable low enables parity, resets to zero
// - RAS shut-off one keeps one RAS active on bank miss
// - One refresh each 15.625 us, or 125 us in slow mode
// - Refresh control: CBR bit 1, slow bit 0, both reset zero
`timescale 1ns/1ps

module drc_refresh #(
  parameter int STD_CYC = drc_pkg::STD_PERIOD_CYC,
  parameter int SLOW_CYC = drc_pkg::SLOW_PERIOD_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Strap pins sampled at reset release
  input wire logic [10:0] i_memory_address_pins,
  // Indexed register port
  input wire logic i_idx_wr,
  input wire logic i_data_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Slot bus timing
  input wire logic i_slot_clk_edge,
  input wire logic i_iochrdy,
  input wire logic [6:0] i_page_reg,
  // Memory controller handshake
  input wire logic i_dram_busy,
  input wire logic i_page_miss_bank_hit,
  input wire logic [3:0] i_total_mem_mb,
  output logic o_refresh_grant,
  // Refresh pins
  output logic o_refresh_n,
  output logic o_memr_n,
  output logic o_cbr_cycle,
  output logic [23:0] o_addr,
  output logic o_addr_oe,
  // Configuration decoded for the memory controller
  output logic [1:0] o_rom_move,
  output logic o_remap_active,
  output logic [3:0] o_memory_map_select,
  output logic [1:0] o_wait_states,
  output logic o_page_mode_en,
  output logic o_parity_en,
  output logic o_ras_shutoff
);
  import drc_pkg::*;

  initial begin
    if (STD_CYC < 1 || SLOW_CYC < STD_CYC || SLOW_CYC >= (1 << 20))
      $error("drc_refresh: bad refresh period counts");
  end

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    drc_state_t st;
    logic [19:0] tick;
    logic pend;
    logic [1:0] scnt;
    logic [11:0] raddr;
    logic strap_dly;
    logic [6:0] map;
    logic [4:0] ctl;
    logic [1:0] refc;
    logic [7:0] idx;
    logic [7:0] rdata;
    logic [1:0] ws;
  } drc_reg_t;

  drc_reg_t s_q, s_d;

  // Read mux used for the data port
  function automatic logic [7:0] rd_mux(input drc_reg_t s,
                                        input logic [7:0] ix);
    if (ix == IDX_MAP)
      rd_mux = {1'b1, s.map};
    else if (ix == IDX_CTL)
      rd_mux = {3'b111, s.ctl};
    else if (ix == IDX_REF)
      rd_mux = {6'h3F, s.refc};
    else
      rd_mux = 8'hFF;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.strap_dly = 1'b0;
    // Straps caught on the first clock after reset release
    if (s_q.strap_dly) begin
      s_d.map = {i_memory_address_pins[8:7],
                 i_memory_address_pins[4],
                 i_memory_address_pins[3:0]};
      s_d.ctl[CTL_WS_BIT] = i_memory_address_pins[5];
      s_d.ctl[CTL_PAGE_MODE_DISABLE_BIT] = i_memory_address_pins[6];
    end
    // Register writes; read-only bits are not stored at all
    if (i_idx_wr)
      s_d.idx = i_wdata;
    if (i_data_wr) begin
      unique case (s_q.idx)
        IDX_MAP: s_d.map = i_wdata[6:0];
        IDX_CTL: s_d.ctl = i_wdata[4:0];
        IDX_REF: s_d.refc = i_wdata[1:0];
        default: ;
      endcase
    end
    s_d.rdata = rd_mux(s_q, s_q.idx);
    unique case (s_q.st)
      DRC_IDLE: begin
        if (s_q.pend)
          s_d.st = DRC_WAIT;
      end
      DRC_WAIT: begin
        // Let an access in flight finish before taking the bus
        if (!i_dram_busy) begin
          s_d.st = DRC_LEAD;
          s_d.pend = 1'b0;
          // One extra edge: the first may come right after the fall
          s_d.scnt = 2'(MEMR_DELAY_SLOTCLK + 1);
        end
      end
      DRC_LEAD: begin
        if (i_slot_clk_edge) begin
          if (s_q.scnt == 2'h1) begin
            s_d.st = DRC_MEMR;
            s_d.scnt = 2'(MEMR_LOW_SLOTCLK);
          end else begin
            s_d.scnt = s_q.scnt - 2'h1;
          end
        end
      end
      DRC_MEMR: begin
        if (i_slot_clk_edge) begin
          if (s_q.scnt > 2'h1)
            s_d.scnt = s_q.scnt - 2'h1;
          else if (i_iochrdy)
            s_d.st = DRC_DONE;
        end
      end
      DRC_DONE: begin
        // Strobes released this cycle; advance the row
        s_d.raddr = s_q.raddr + 12'h1;
        s_d.st = DRC_IDLE;
      end
      default: s_d.st = DRC_IDLE;
    endcase
    // Period tick after the sequencer, so a tick in the cycle a
    // refresh is taken still leaves a request pending
    if (s_q.tick == 20'h0) begin
      s_d.tick = s_q.refc[REF_SLOW_BIT] ? 20'(SLOW_CYC - 1)
                                        : 20'(STD_CYC - 1);
      s_d.pend = 1'b1;
    end else begin
      s_d.tick = s_q.tick - 20'h1;
    end
    // Wait states for the access controller
    if (s_q.ctl[CTL_WS_BIT])
      s_d.ws = 2'h1;
    else if (i_page_miss_bank_hit)
      s_d.ws = s_q.ctl[CTL_FAST_BIT] ? 2'h3 : 2'h2;
    else
      s_d.ws = 2'h0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.st <= DRC_IDLE;
      s_q.strap_dly <= 1'b1;
      s_q.ctl[CTL_FAST_BIT] <= RST_FAST;
      s_q.ctl[CTL_PAR_BIT] <= RST_PAR_N;
      s_q.ctl[CTL_RAS_BIT] <= RST_RAS_SHUTOFF;
      s_q.refc <= RST_REFRESH_CONTROL_REGISTER;
      s_q.tick <= 20'(STD_CYC - 1);
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 8'hFF;
      o_refresh_grant <= 1'b0;
      o_refresh_n <= 1'b1;
      o_memr_n <= 1'b1;
      o_cbr_cycle <= 1'b0;
      o_addr <= 24'h0;
      o_addr_oe <= 1'b0;
      o_rom_move <= 2'h0;
      o_remap_active <= 1'b0;
      o_memory_map_select <= 4'h0;
      o_wait_states <= 2'h0;
      o_page_mode_en <= 1'b0;
      o_parity_en <= 1'b0;
      o_ras_shutoff <= 1'b0;
    end else begin
      o_rdata <= s_d.rdata;
      o_refresh_grant <= s_d.st == DRC_LEAD || s_d.st == DRC_MEMR;
      // Refresh strobe covers both phases, read strobe only the second
      o_refresh_n <= !(s_d.st == DRC_LEAD || s_d.st == DRC_MEMR);
      o_memr_n <= !(s_d.st == DRC_MEMR);
      o_cbr_cycle <= s_d.refc[REF_CBR_BIT];
      o_addr <= {i_page_reg, 5'h1F, s_d.raddr};
      o_addr_oe <= s_d.st == DRC_LEAD || s_d.st == DRC_MEMR;
      o_rom_move <= s_d.map[6:5];
      // Remap only honoured for 1M to 4M total memory
      o_remap_active <= s_d.map[4] && i_total_mem_mb >= 4'h1
                        && i_total_mem_mb <= 4'h4;
      o_memory_map_select <= s_d.map[3:0];
      o_wait_states <= s_d.ws;
      o_page_mode_en <= !s_d.ctl[CTL_PAGE_MODE_DISABLE_BIT];
      o_parity_en <= !s_d.ctl[CTL_PAR_BIT];
      o_ras_shutoff <= s_d.ctl[CTL_RAS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_memr_after_ref;
    @(posedge i_sys_clk) disable iff (i_rst)
      $fell(o_memr_n) |-> !o_refresh_n && $past(!o_refresh_n);
  endproperty
  a_memr_after_ref: assert property (p_memr_after_ref)
    else $error("read strobe fell without refresh lead");

  property p_memr_in_ref;
    @(posedge i_sys_clk) disable iff (i_rst)
      !o_memr_n |-> !o_refresh_n;
  endproperty
  a_memr_in_ref: assert property (p_memr_in_ref)
    else $error("read strobe low outside refresh");

  property p_hold_rdy;
    @(posedge i_sys_clk) disable iff (i_rst)
      (s_q.st == DRC_MEMR && !i_iochrdy) |=> !o_memr_n && !o_refresh_n;
  endproperty
  a_hold_rdy: assert property (p_hold_rdy)
    else $error("strobes released while slot not ready");

  property p_inc;
    @(posedge i_sys_clk) disable iff (i_rst)
      $rose(o_refresh_n) |=> s_q.raddr == $past(s_q.raddr) + 12'h1;
  endproperty
  a_inc: assert property (p_inc)
    else $error("refresh counter not advanced");

  property p_addr_hi;
    @(posedge i_sys_clk) disable iff (i_rst)
      o_addr_oe |-> o_addr[16:12] == 5'h1F;
  endproperty
  a_addr_hi: assert property (p_addr_hi)
    else $error("address 16-12 not high in refresh");

  property p_rd_map;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_q.idx == IDX_MAP && !i_idx_wr |=> o_rdata[7];
  endproperty
  a_rd_map: assert property (p_rd_map)
    else $error("map bit 7 not one");

  property p_ws;
    @(posedge i_sys_clk) disable iff (i_rst)
      s_q.ctl[CTL_WS_BIT] |=> s_q.ws == 2'h1;
  endproperty
  a_ws: assert property (p_ws)
    else $error("wait state count wrong");

  property p_busy;
    @(posedge i_sys_clk) disable iff (i_rst)
      (s_q.st == DRC_WAIT && i_dram_busy) |=> o_refresh_n;
  endproperty
  a_busy: assert property (p_busy)
    else $error("refresh started during access");

  property p_ref_reset;
    @(posedge i_sys_clk) $fell(i_rst) |-> s_q.refc == 2'h0;
  endproperty
  a_ref_reset: assert property (p_ref_reset)
    else $error("refresh control not reset");

endmodule

// [testbench/drc_slot_card.sv]
/*
  Slot card model: free slot clock pulses, ready stretch, address latch.
  Assumes the refresh strobes and address of the refresh block.
*/
`timescale 1ns/1ps
module drc_slot_card (
  // Clock
  input wire logic i_sys_clk,
  // Refresh pins, stretch length in clocks
  input wire logic i_refresh_n,
  input wire logic i_memr_n,
  input wire logic [7:0] i_addr_lo,
  input wire logic [7:0] i_hold,
  // Slot side
  output logic o_slot_clk_edge,
  output logic o_iochrdy,
  output logic [7:0] o_sa
);
  int div = 0;
  int left = 0;
  logic memr_q = 1'b1;
  // --------------------
  // Slot clock and ready
  // --------------------
  initial begin
    o_slot_clk_edge = 1'b0;
    o_iochrdy = 1'b1;
    o_sa = 8'h00;
  end
  // Ready falls once the read strobe is seen low; pull-up otherwise
  always @(posedge i_sys_clk) begin
    #1;
    div = (div + 1) % 3;
    o_slot_clk_edge = (div == 0);
    if (memr_q && !i_memr_n) left = i_hold;
    memr_q = i_memr_n;
    if (left > 0) left = left - 1;
    o_iochrdy = (left == 0);
    if (!i_refresh_n) o_sa = i_addr_lo;
  end
endmodule

// [testbench/drc_refresh_test.sv]
/*
  Self-checking bench for the refresh and configuration block.
  Assumes drc_slot_card as the slot side and a 40 MHz clock.
*/
`timescale 1ns/1ps
module drc_refresh_test;
  import drc_pkg::*;
  localparam int STD = 40;
  localparam int SLOW = 80;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_idx_wr = 1'b0, i_data_wr = 1'b0;
  logic [10:0] pins;
  logic [7:0] i_wdata = 8'h00, o_rdata, d, hold = 8'h00, sa;
  logic slot_edge, iochrdy, i_dram_busy = 1'b0, pmbh = 1'b0;
  logic [6:0] page;
  logic [3:0] tot = 4'h0, o_memory_map_select;
  logic o_refresh_grant, o_refresh_n, o_memr_n, o_cbr_cycle, o_addr_oe;
  logic [23:0] o_addr;
  logic [1:0] o_rom_move, o_wait_states;
  logic o_remap_active, o_page_mode_en, o_parity_en, o_ras_shutoff;
  logic en_rnd = 1'b0, pr_ref = 1'b1, pr_memr = 1'b1, prv_busy, prv_rdy;
  int bad_count = 0, comparisons = 0, m_map, m_ctl, m_ref, m_cnt = 0;
  int cyc = 0, last_fall = 0, per_chk = 0, bef = 0, low = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  // Small periods keep the run short
  drc_refresh #(.STD_CYC(STD), .SLOW_CYC(SLOW)) dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_memory_address_pins(pins),
    .i_idx_wr(i_idx_wr), .i_data_wr(i_data_wr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_slot_clk_edge(slot_edge), .i_iochrdy(iochrdy),
    .i_page_reg(page), .i_dram_busy(i_dram_busy),
    .i_page_miss_bank_hit(pmbh), .i_total_mem_mb(tot),
    .o_refresh_grant(o_refresh_grant), .o_refresh_n(o_refresh_n),
    .o_memr_n(o_memr_n), .o_cbr_cycle(o_cbr_cycle), .o_addr(o_addr),
    .o_addr_oe(o_addr_oe), .o_rom_move(o_rom_move),
    .o_remap_active(o_remap_active),
    .o_memory_map_select(o_memory_map_select),
    .o_wait_states(o_wait_states), .o_page_mode_en(o_page_mode_en),
    .o_parity_en(o_parity_en), .o_ras_shutoff(o_ras_shutoff));

  drc_slot_card card (
    .i_sys_clk(i_sys_clk), .i_refresh_n(o_refresh_n), .i_memr_n(o_memr_n),
    .i_addr_lo(o_addr[7:0]), .i_hold(hold), .o_slot_clk_edge(slot_edge),
    .o_iochrdy(iochrdy), .o_sa(sa));

  // ------------------
  // Checking and tasks
  // ------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] v);
    i_wdata = ix;
    i_idx_wr = 1'b1;
    @(posedge i_sys_clk) #1;
    i_idx_wr = 1'b0;
    i_data_wr = 1'b1;
    i_wdata = v;
    @(posedge i_sys_clk) #1;
    i_data_wr = 1'b0;
  endtask

  // Index write, then two edges so the registered read data settles
  task automatic rd(input logic [7:0] ix, input int e);
    i_wdata = ix;
    i_idx_wr = 1'b1;
    @(posedge i_sys_clk) #1;
    i_idx_wr = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk(o_rdata, e);
  endtask

  task automatic chk_dec();
    int ws;
    ws = m_ctl[4] ? 1 : (pmbh ? (m_ctl[3] ? 3 : 2) : 0);
    chk(o_rom_move, m_map[6:5]);
    chk(o_remap_active, m_map[4] && tot >= 1 && tot <= 4);
    chk(o_memory_map_select, m_map[3:0]);
    chk(o_wait_states, ws);
    chk(o_page_mode_en, !m_ctl[2]);
    chk(o_parity_en, !m_ctl[1]);
    chk(o_ras_shutoff, m_ctl[0]);
  endtask

  // Refresh type changes only while accesses hold refresh off
  task automatic set_ref(input logic [7:0] v);
    en_rnd = 1'b0;
    @(posedge i_sys_clk) #1; // Random driver stands down first
    i_dram_busy = 1'b1;
    for (int t = 0; t < 100 && o_refresh_grant !== 1'b0; t++)
      @(posedge i_sys_clk) #1;
    wr(8'h06, v);
    m_ref = v | 8'hFC;
    rd(8'h06, m_ref);
    i_dram_busy = 1'b0;
  endtask

  task automatic run_per(input int n);
    per_chk = 1;
    repeat (n) @(posedge i_sys_clk);
    #1 per_chk = 0;
  endtask

  // Random accesses, never started while a refresh holds the bus
  always @(posedge i_sys_clk) begin
    #1;
    if (en_rnd) i_dram_busy = o_refresh_grant ? 1'b0 : ($urandom % 4 == 0);
  end

  // Strobe monitor; sees values from before each edge's update
  always @(posedge i_sys_clk) begin
    cyc++;
    if (!i_rst) begin
      if (pr_ref && !o_refresh_n) begin
        chk(prv_busy, 0);
        if (per_chk > 2)
          chk(cyc - last_fall, m_ref[0] ? SLOW : STD);
        if (per_chk > 0) per_chk++;
        last_fall = cyc;
        bef = 0;
        low = 0;
      end
      if (!o_refresh_n) begin
        chk({o_refresh_grant, o_addr_oe, o_cbr_cycle},
            {2'b11, m_ref[1]});
        chk(o_addr, {page, 5'h1F, m_cnt[11:0]});
        if (slot_edge && o_memr_n) bef++;
      end
      if (!o_memr_n && slot_edge) low++;
      if (pr_memr && !o_memr_n)
        chk(bef > MEMR_DELAY_SLOTCLK, 1);
      if (!pr_memr && o_memr_n) begin
        chk(hold == 0 ? low == 2 : low >= 2, 1);
        chk(prv_rdy, 1);
      end
      if (!pr_ref && o_refresh_n) begin
        chk({o_memr_n, sa}, {1'b1, m_cnt[7:0]});
        m_cnt = (m_cnt + 1) % 4096;
      end
    end
    pr_ref = o_refresh_n;
    pr_memr = o_memr_n;
    prv_busy = i_dram_busy;
    prv_rdy = iochrdy;
  end

  // Watchdog: whole sequence needs about 1300 clocks
  initial begin
    #(6000 * 25);
    bad_count++;
    wrap_up();
  end

  // ----------
  // Main tests
  // ----------
  initial begin
    void'($urandom(13));
    pins = 11'($urandom);
    page = 7'($urandom);
    repeat (2) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    m_map = {1'b1, pins[8], pins[7], pins[4], pins[3:0]};
    m_ctl = {3'b111, pins[5], 1'b0, pins[6], 2'b00};
    m_ref = 8'hFC;
    repeat (2) @(posedge i_sys_clk);
    #1 en_rnd = 1'b1;
    rd(8'h03, m_map);
    rd(8'h05, m_ctl);
    rd(8'h06, m_ref);
    rd(8'h02, 8'hFF);
    chk_dec();
    for (int k = 0; k < 8; k++) begin
      pmbh = 1'($urandom);
      tot = 4'($urandom % 6);
      d = 8'($urandom);
      wr(8'h03, d);
      m_map = d | 8'h80;
      d = 8'($urandom);
      wr(8'h05, d);
      m_ctl = d | 8'hE0;
      rd(8'h03, m_map);
      rd(8'h05, m_ctl);
      chk_dec();
    end
    set_ref(8'h00);
    run_per(7 * STD);
    set_ref(8'h03);
    run_per(7 * SLOW);
    hold = 8'd20;
    en_rnd = 1'b1;
    repeat (4 * SLOW) @(posedge i_sys_clk);
    #1 chk(m_cnt > 10, 1);
    wrap_up();
  end
endmodule
